// file: core/cmaddr_core.sv
// Stack, program counter, pointer and banked data memory logic of the CPU core
`timescale 1ns/1ps
module cmaddr_core (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        call_req,
  input  wire logic        irq_req,
  input  wire logic        ret_req,
  input  wire logic        jump_req,
  input  wire logic [14:0] jump_addr,
  input  wire logic        step,
  input  wire logic        stack_reset_en,
  output logic      [14:0] pc_r,
  output logic      [14:0] prog_addr,
  input  wire logic [13:0] prog_rdata,
  output logic             in_endurance_region,
  output logic             soft_reset_req_r,
  output logic             stack_overflow_flag_r,
  output logic             stack_underflow_flag_r,
  input  wire logic        flags_clear,
  input  wire logic        dm_wr,
  input  wire logic        dm_rd,
  input  wire logic        dm_indirect,
  input  wire logic        dm_ptr_sel,
  input  wire logic [6:0]  dm_offset,
  input  wire logic [7:0]  dm_wdata,
  output logic      [7:0]  dm_rdata_r,
  output logic             dm_stall,
  input  wire logic        result_flags_update,
  input  wire logic [2:0]  result_flags,
  input  wire logic        status_clear,
  input  wire logic        wdt_timeout,
  input  wire logic        sleep_enter,
  input  wire logic        wdt_clear,
  output logic      [7:0]  status_r,
  output logic      [4:0]  bank_selector_r,
  output logic      [15:0] ptr0_r,
  output logic      [15:0] ptr1_r,
  output logic      [6:0]  periph_addr,
  output logic             periph_wr,
  output logic             periph_rd,
  input  wire logic [7:0]  periph_rdata
);
  logic [14:0] stack_mem [cmaddr_pkg::STACK_DEPTH];
  logic [4:0]  sp_r;
  logic [7:0]  gpr_mem [cmaddr_pkg::GPR_BANKS * cmaddr_pkg::GPR_BYTES];
  logic [7:0]  common_mem [16];
  logic        stall_done_r;
  logic [15:0] ptr_cur;
  logic [11:0] eff_addr;
  logic [4:0]  eff_bank;
  logic [6:0]  eff_off;
  logic        ptr_prog;
  logic        lin_hit;
  logic [7:0]  lin_idx;
  logic        gpr_hit;
  logic [7:0]  gpr_idx;
  logic [7:0]  rd_value;
  logic        push_ev;
  logic        pop_ev;
  logic [14:0] ret_addr;
  logic        core_wr;
  logic        stack_full;
  logic        stack_empty;
  logic        push_ok;
  logic        pop_ok;
  logic        ind_unmapped;
  logic        core_hit;
  logic        periph_hit;
  logic        common_hit;
  logic        gpr_dir_hit;
  logic [7:0]  gpr_bank_base;
  logic [7:0]  core_rdata;
  logic [14:0] pc_nxt;
  logic [2:0]  arith_flags_r;
  logic        timeout_flag_r;
  logic        sleep_flag_r;

  assign push_ev = call_req | irq_req;
  assign pop_ev  = ret_req & ~push_ev;
  assign ret_addr = 15'(pc_r + 15'h0001);

  assign stack_full  = (sp_r == 5'(cmaddr_pkg::STACK_DEPTH));
  assign stack_empty = (sp_r == 5'h00);
  assign push_ok     = push_ev & ~stack_full;
  assign pop_ok      = pop_ev & ~stack_empty;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sp_r <= 5'h00;
    end else if (soft_reset_req_r) begin
      sp_r <= 5'h00;
    end else if (push_ok) begin
      sp_r <= 5'(sp_r + 5'h01);
    end else if (pop_ok) begin
      sp_r <= 5'(sp_r - 5'h01);
    end
  end

  always_ff @(posedge clk) begin
    if (push_ok) begin
      stack_mem[sp_r[3:0]] <= ret_addr;
    end
  end

  // Overflow flag; set wins over clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stack_overflow_flag_r <= 1'b0;
    end else if (push_ev && stack_full) begin
      stack_overflow_flag_r <= 1'b1;
    end else if (flags_clear) begin
      stack_overflow_flag_r <= 1'b0;
    end
  end

  // Underflow flag; set wins over clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stack_underflow_flag_r <= 1'b0;
    end else if (pop_ev && stack_empty) begin
      stack_underflow_flag_r <= 1'b1;
    end else if (flags_clear) begin
      stack_underflow_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      soft_reset_req_r <= 1'b0;
    end else begin
      soft_reset_req_r <= stack_reset_en & ((push_ev & stack_full) | (pop_ev & stack_empty));
    end
  end

  always_comb begin
    pc_nxt = pc_r;
    if (soft_reset_req_r) begin
      pc_nxt = cmaddr_pkg::RESET_VEC;
    end else if (irq_req) begin
      pc_nxt = cmaddr_pkg::IRQ_VEC;
    end else if (call_req || jump_req) begin
      pc_nxt = jump_addr & cmaddr_pkg::PROG_MASK;
    end else if (pop_ok) begin
      pc_nxt = stack_mem[4'(sp_r - 5'h01)] & cmaddr_pkg::PROG_MASK;
    end else if (step && !dm_stall) begin
      pc_nxt = 15'(pc_r + 15'h0001) & cmaddr_pkg::PROG_MASK;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_r <= cmaddr_pkg::RESET_VEC;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  assign ptr_cur  = dm_ptr_sel ? ptr1_r : ptr0_r;
  assign ptr_prog = dm_indirect & ptr_cur[cmaddr_pkg::PTR_PROG_BIT];
  assign eff_addr = dm_indirect ? ptr_cur[11:0] : {bank_selector_r, dm_offset};
  assign eff_bank = eff_addr[11:7];
  assign eff_off  = eff_addr[6:0];

  assign lin_hit = dm_indirect & ~ptr_prog & (ptr_cur >= cmaddr_pkg::LINEAR_BASE)
                   & (ptr_cur <= cmaddr_pkg::LINEAR_LAST);
  assign lin_idx = 8'(ptr_cur - cmaddr_pkg::LINEAR_BASE);
  // Pointer addresses outside every mapped area
  assign ind_unmapped = dm_indirect & ~ptr_prog & ~lin_hit & (ptr_cur[14:12] != 3'h0);
  assign core_hit     = ~ptr_prog & ~lin_hit & ~ind_unmapped & (eff_off <= cmaddr_pkg::CORE_LAST);
  assign periph_hit   = ~ptr_prog & ~lin_hit & ~ind_unmapped & (eff_off >= cmaddr_pkg::PERIPH_FIRST)
                        & (eff_off <= cmaddr_pkg::PERIPH_LAST);
  assign common_hit   = ~ptr_prog & ~lin_hit & ~ind_unmapped & (eff_off >= cmaddr_pkg::COMMON_FIRST);
  // General RAM exists in the first banks only, 80 bytes each
  assign gpr_dir_hit  = ~ptr_prog & ~lin_hit & ~ind_unmapped & (eff_off >= cmaddr_pkg::GPR_FIRST)
                        & (eff_off <= cmaddr_pkg::GPR_LAST) & (eff_bank < 5'(cmaddr_pkg::GPR_BANKS));
  assign gpr_bank_base = eff_bank[0] ? 8'(cmaddr_pkg::GPR_BYTES) : 8'h00;
  assign gpr_hit = lin_hit | gpr_dir_hit;
  assign gpr_idx = lin_hit ? lin_idx
                 : 8'(gpr_bank_base + 8'(eff_off - cmaddr_pkg::GPR_FIRST));

  assign prog_addr = ptr_prog ? (ptr_cur[14:0] & cmaddr_pkg::PROG_MASK) : pc_r;
  assign in_endurance_region = (prog_addr >= cmaddr_pkg::HEF_FIRST) && (prog_addr <= cmaddr_pkg::HEF_LAST);

  // One extra cycle for program memory reads
  assign dm_stall = dm_rd & ptr_prog & ~stall_done_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stall_done_r <= 1'b0;
    end else begin
      stall_done_r <= dm_stall;
    end
  end

  assign periph_addr = eff_off;
  assign periph_rd = dm_rd & periph_hit;
  // No writes to program memory through the port
  assign periph_wr = dm_wr & periph_hit;
  assign core_wr = dm_wr & core_hit;

  always_ff @(posedge clk) begin
    if (dm_wr && gpr_hit && !ptr_prog) begin
      gpr_mem[gpr_idx] <= dm_wdata;
    end
  end

  // Common RAM shared by all banks
  always_ff @(posedge clk) begin
    if (dm_wr && common_hit) begin
      common_mem[eff_off[3:0]] <= dm_wdata;
    end
  end

  cmaddr_ptr_reg #(
    .LOW_OFF  (cmaddr_pkg::CORE_PTR0L),
    .HIGH_OFF (cmaddr_pkg::CORE_PTR0H)
  ) u_ptr0 (
    .clk     (clk),
    .reset_n (reset_n),
    .wr_en   (core_wr),
    .offset  (eff_off),
    .wdata   (dm_wdata),
    .value_r (ptr0_r)
  );

  cmaddr_ptr_reg #(
    .LOW_OFF  (cmaddr_pkg::CORE_PTR1L),
    .HIGH_OFF (cmaddr_pkg::CORE_PTR1H)
  ) u_ptr1 (
    .clk     (clk),
    .reset_n (reset_n),
    .wr_en   (core_wr),
    .offset  (eff_off),
    .wdata   (dm_wdata),
    .value_r (ptr1_r)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bank_selector_r <= 5'h00;
    end else if (core_wr && eff_off == cmaddr_pkg::CORE_BANK) begin
      bank_selector_r <= dm_wdata[4:0];
    end
  end

  // Result wins over the write; clear sets Z
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      arith_flags_r <= cmaddr_pkg::STATUS_RESET[2:0];
    end else if (status_clear) begin
      arith_flags_r[cmaddr_pkg::ST_Z] <= 1'b1;
    end else if (result_flags_update) begin
      arith_flags_r <= result_flags;
    end else if (core_wr && eff_off == cmaddr_pkg::CORE_STATUS) begin
      arith_flags_r <= dm_wdata[2:0];
    end
  end

  // Time-out flag follows watchdog events and sleep entry only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timeout_flag_r <= cmaddr_pkg::STATUS_RESET[cmaddr_pkg::ST_TO];
    end else if (wdt_timeout) begin
      timeout_flag_r <= 1'b0;
    end else if (wdt_clear || sleep_enter) begin
      timeout_flag_r <= 1'b1;
    end
  end

  // Sleep flag follows sleep and watchdog clear only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sleep_flag_r <= cmaddr_pkg::STATUS_RESET[cmaddr_pkg::ST_PD];
    end else if (sleep_enter) begin
      sleep_flag_r <= 1'b0;
    end else if (wdt_clear) begin
      sleep_flag_r <= 1'b1;
    end
  end

  // Upper three bits always read as zero
  assign status_r = {3'h0, timeout_flag_r, sleep_flag_r, arith_flags_r};

  // Core register values, the same in every bank
  always_comb begin
    core_rdata = 8'h00;
    unique case (eff_off)
      cmaddr_pkg::CORE_STATUS: core_rdata = status_r & cmaddr_pkg::STATUS_IMPL;
      cmaddr_pkg::CORE_PTR0L:  core_rdata = ptr0_r[7:0];
      cmaddr_pkg::CORE_PTR0H:  core_rdata = ptr0_r[15:8];
      cmaddr_pkg::CORE_PTR1L:  core_rdata = ptr1_r[7:0];
      cmaddr_pkg::CORE_PTR1H:  core_rdata = ptr1_r[15:8];
      cmaddr_pkg::CORE_BANK:   core_rdata = {3'h0, bank_selector_r};
      default:                 core_rdata = 8'h00;
    endcase
  end

  // Read mux
  always_comb begin
    rd_value = 8'h00;
    if (ptr_prog) begin
      rd_value = prog_rdata[7:0];
    end else if (gpr_hit) begin
      rd_value = gpr_mem[gpr_idx];
    end else if (ind_unmapped) begin
      rd_value = 8'h00;
    end else if (common_hit) begin
      rd_value = common_mem[eff_off[3:0]];
    end else if (periph_hit) begin
      rd_value = periph_rdata;
    end else if (core_hit) begin
      rd_value = core_rdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dm_rdata_r <= 8'h00;
    end else if (dm_rd && !dm_stall) begin
      dm_rdata_r <= rd_value;
    end
  end
endmodule : cmaddr_core

// One byte-writable 16-bit pointer register
module cmaddr_ptr_reg #(
  parameter logic [6:0] LOW_OFF  = cmaddr_pkg::CORE_PTR0L,
  parameter logic [6:0] HIGH_OFF = cmaddr_pkg::CORE_PTR0H
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        wr_en,
  input  wire logic [6:0]  offset,
  input  wire logic [7:0]  wdata,
  output logic      [15:0] value_r
);
  // Low and high bytes written one at a time
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      value_r <= 16'h0000;
    end else if (wr_en && offset == LOW_OFF) begin
      value_r[7:0] <= wdata;
    end else if (wr_en && offset == HIGH_OFF) begin
      value_r[15:8] <= wdata;
    end
  end
endmodule : cmaddr_ptr_reg

// file: include/cmaddr_pkg.sv
// Constants for the CPU memory addressing block
package cmaddr_pkg;
  localparam int STACK_DEPTH = 16;
  localparam int PC_W = 15;
  localparam int PTR_W = 16;
  localparam int DADDR_W = 12;
  localparam logic [14:0] PROG_LAST = 15'h07FF;
  localparam logic [14:0] PROG_MASK = 15'h07FF;
  localparam logic [14:0] RESET_VEC = 15'h0000;
  localparam logic [14:0] IRQ_VEC = 15'h0004;
  localparam logic [14:0] HEF_FIRST = 15'h0780;
  localparam logic [14:0] HEF_LAST = 15'h07FF;
  localparam int PTR_PROG_BIT = 15;
  localparam logic [6:0] CORE_LAST = 7'h0B;
  localparam logic [6:0] PERIPH_FIRST = 7'h0C;
  localparam logic [6:0] PERIPH_LAST = 7'h1F;
  localparam logic [6:0] GPR_FIRST = 7'h20;
  localparam logic [6:0] GPR_LAST = 7'h6F;
  localparam logic [6:0] COMMON_FIRST = 7'h70;
  localparam int GPR_BANKS = 2;
  localparam int GPR_BYTES = 80;
  localparam logic [15:0] LINEAR_BASE = 16'h2000;
  localparam logic [15:0] LINEAR_LAST = 16'h209F;
  localparam logic [6:0] CORE_STATUS = 7'h03;
  localparam logic [6:0] CORE_PTR0L = 7'h04;
  localparam logic [6:0] CORE_PTR0H = 7'h05;
  localparam logic [6:0] CORE_PTR1L = 7'h06;
  localparam logic [6:0] CORE_PTR1H = 7'h07;
  localparam logic [6:0] CORE_BANK = 7'h08;
  localparam int ST_TO = 4;
  localparam int ST_PD = 3;
  localparam int ST_Z = 2;
  localparam int ST_DC = 1;
  localparam int ST_C = 0;
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [7:0] STATUS_IMPL = 8'h1F;
endpackage : cmaddr_pkg

// file: verification/cmaddr_mem_model.sv
// Program memory and peripheral register model facing the addressing core
`timescale 1ns/1ps
module cmaddr_mem_model (
  input  wire logic        clk,
  input  wire logic [14:0] prog_addr,
  output logic      [13:0] prog_rdata,
  input  wire logic [6:0]  periph_addr,
  input  wire logic        periph_wr,
  input  wire logic        periph_rd,
  input  wire logic [7:0]  dm_wdata,
  output logic      [7:0]  periph_rdata
);
  logic [7:0] regs [32];
  logic       tog = 1'b0;
  // Word pattern lets the bench predict the low byte from the address
  assign prog_rdata = {prog_addr[5:0], prog_addr[7:0]};
  // Unselected bus shows a pattern that changes every cycle
  assign periph_rdata = periph_rd ? regs[periph_addr[4:0]] : {8{tog}};
  always @(posedge clk) begin
    tog <= ~tog;
    if (periph_wr) begin
      regs[periph_addr[4:0]] <= dm_wdata;
    end
  end
endmodule : cmaddr_mem_model

// file: verification/cmaddr_core_monitor.sv
// Port checks of the memory addressing core
`timescale 1ns/1ps
module cmaddr_core_monitor (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        irq_req,
  input wire logic        stack_reset_en,
  input wire logic [14:0] pc_r,
  input wire logic [14:0] prog_addr,
  input wire logic [13:0] prog_rdata,
  input wire logic        in_endurance_region,
  input wire logic        soft_reset_req_r,
  input wire logic        stack_overflow_flag_r,
  input wire logic        stack_underflow_flag_r,
  input wire logic        dm_wr,
  input wire logic        dm_rd,
  input wire logic        dm_indirect,
  input wire logic        dm_ptr_sel,
  input wire logic [6:0]  dm_offset,
  input wire logic [7:0]  dm_wdata,
  input wire logic [7:0]  dm_rdata_r,
  input wire logic        dm_stall,
  input wire logic        result_flags_update,
  input wire logic [2:0]  result_flags,
  input wire logic        status_clear,
  input wire logic        wdt_timeout,
  input wire logic        sleep_enter,
  input wire logic        wdt_clear,
  input wire logic [7:0]  status_r,
  input wire logic [4:0]  bank_selector_r,
  input wire logic [15:0] ptr0_r,
  input wire logic [15:0] ptr1_r
);
  logic       quiet;
  logic       st_wr;
  logic [7:0] prog_low;
  logic [4:0] bank_in;
  logic [1:0] wdt_bits;
  assign quiet    = !wdt_timeout && !sleep_enter && !wdt_clear;
  assign st_wr    = dm_wr && !dm_indirect && dm_offset == cmaddr_pkg::CORE_STATUS;
  assign prog_low = prog_rdata[7:0];
  assign bank_in  = dm_wdata[4:0];
  assign wdt_bits = status_r[4:3];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  chk_prog_wrap: assert property (prog_addr <= cmaddr_pkg::PROG_LAST)
    else $error("program address past last word");
  chk_hef_flag: assert property (in_endurance_region ==
    (prog_addr >= cmaddr_pkg::HEF_FIRST && prog_addr <= cmaddr_pkg::HEF_LAST))
    else $error("endurance flag wrong");
  chk_irq_vector: assert property (irq_req |=> pc_r == cmaddr_pkg::IRQ_VEC)
    else $error("interrupt vector wrong");
  chk_stall_source: assert property (dm_stall |-> dm_rd && dm_indirect && (dm_ptr_sel ? ptr1_r[15] : ptr0_r[15]))
    else $error("stall without program read");
  chk_prog_byte: assert property (dm_stall ##1 dm_rd |=> dm_rdata_r == $past(prog_low))
    else $error("program low byte wrong");
  chk_status_clear: assert property (status_clear && !dm_wr && quiet |=>
    status_r[7:5] == 3'h0 && status_r[cmaddr_pkg::ST_Z] && wdt_bits == $past(wdt_bits))
    else $error("status clear wrong");
  chk_flag_keep: assert property (st_wr && quiet |=> wdt_bits == $past(wdt_bits))
    else $error("timeout or sleep flag written");
  chk_result_wins: assert property (st_wr && result_flags_update |=> status_r[2:0] == $past(result_flags))
    else $error("result flags not kept");
  chk_bank_load: assert property (dm_wr && !dm_indirect && dm_offset == cmaddr_pkg::CORE_BANK
    |=> bank_selector_r == $past(bank_in))
    else $error("bank selector not loaded");
  chk_stack_reset: assert property (($rose(stack_overflow_flag_r) || $rose(stack_underflow_flag_r))
    && stack_reset_en |-> ##[0:1] soft_reset_req_r)
    else $error("no software reset request");
  cover property (dm_stall);
  cover property (stack_overflow_flag_r);
  cover property (stack_underflow_flag_r);
endmodule : cmaddr_core_monitor

bind cmaddr_core cmaddr_core_monitor u_mon (.*);

// file: verification/cmaddr_core_tb_top.sv
// Directed bench for the memory addressing core
`timescale 1ns/1ps
module cmaddr_core_tb_top;
  logic        clk, reset_n, stack_reset_en, dm_wr, dm_rd, dm_indirect, dm_ptr_sel, dm_stall;
  logic        result_flags_update, in_endurance_region, soft_reset_req_r, periph_wr, periph_rd;
  logic        stack_overflow_flag_r, stack_underflow_flag_r;
  logic [6:0]  req, dm_offset, periph_addr;
  logic [14:0] jump_addr, pc_r, prog_addr;
  logic [13:0] prog_rdata;
  logic [7:0]  dm_wdata, dm_rdata_r, status_r, periph_rdata;
  logic [2:0]  result_flags;
  logic [4:0]  bank_selector_r;
  logic [15:0] ptr0_r, ptr1_r;
  int          n_fail, checked;

  cmaddr_core u_dut (.*, .irq_req(req[3]), .call_req(req[2]), .ret_req(req[1]), .jump_req(req[0]),
    .status_clear(req[4]), .step(req[5]), .flags_clear(req[6]), .wdt_timeout(1'b0),
    .sleep_enter(1'b0), .wdt_clear(1'b0));
  cmaddr_mem_model u_mem (.*);

  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  // One-cycle pulse on request k: 0 jump, 1 return, 2 call, 3 irq, 4 clear, 5 step, 6 flag clear
  task automatic go(input int k, input logic [14:0] a);
    @(posedge clk);
    req       <= 7'(1 << k);
    jump_addr <= a;
    @(posedge clk);
    req <= '0;
    #1;
  endtask : go
  task automatic wr(input logic [6:0] o, input logic [7:0] d, input logic [3:0] u);
    @(posedge clk);
    dm_wr                               <= 1'b1;
    dm_offset                           <= o;
    dm_wdata                            <= d;
    {result_flags_update, result_flags} <= u;
    @(posedge clk);
    dm_wr               <= 1'b0;
    result_flags_update <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [1:0] m, input logic [6:0] o, input int n, input logic [7:0] e);
    @(posedge clk);
    dm_rd                     <= 1'b1;
    {dm_indirect, dm_ptr_sel} <= m;
    dm_offset                 <= o;
    repeat (n) @(posedge clk);
    dm_rd       <= 1'b0;
    dm_indirect <= 1'b0;
    #1;
    cmp(16'(dm_rdata_r), 16'(e));
  endtask : rd
  task automatic results;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    n_fail++;
    results();
  end
  initial begin
    {reset_n, stack_reset_en, dm_wr, dm_rd, dm_indirect, dm_ptr_sel, result_flags_update} = '0;
    {req, jump_addr, dm_offset, dm_wdata, result_flags} = '0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    cmp(16'(pc_r), 16'h0000);
    go(3, 15'h0000);
    cmp(16'(pc_r), 16'h0004);
    for (int i = 0; i < 15; i++) go(2, 15'(16 + 8 * i));
    cmp(16'(stack_overflow_flag_r), 16'h0000);
    go(2, 15'h0300);
    cmp(16'(stack_overflow_flag_r), 16'h0001);
    for (int i = 13; i >= -1; i--) begin
      go(1, 15'h0000);
      cmp(16'(pc_r), 16'(i < 0 ? 5 : 17 + 8 * i));
    end
    go(1, 15'h0000);
    cmp(16'(pc_r), 16'h0001);
    stack_reset_en <= 1'b1;
    go(1, 15'h0000);
    cmp(16'(stack_underflow_flag_r), 16'h0001);
    cmp(16'(soft_reset_req_r), 16'h0001);
    go(6, 15'h0000);
    go(0, 15'h0805);
    cmp(16'(prog_addr), 16'h0005);
    go(0, 15'h077F);
    cmp(16'(in_endurance_region), 16'h0000);
    go(5, 15'h0000);
    cmp(16'(in_endurance_region), 16'h0001);
    go(0, 15'h07FF);
    go(5, 15'h0000);
    cmp(16'(prog_addr), 16'h0000);
    wr(7'h03, 8'hFF, 4'h0);
    cmp(16'(status_r), 16'h001F);
    wr(7'h03, 8'hFF, 4'hA);
    cmp(16'(status_r), 16'h001A);
    go(4, 15'h0000);
    cmp(16'(status_r), 16'h001E);
    wr(7'h08, 8'h00, 4'h0);
    wr(7'h20, 8'h3C, 4'h0);
    wr(7'h70, 8'hA5, 4'h0);
    wr(7'h0C, 8'h77, 4'h0);
    wr(7'h08, 8'h1F, 4'h0);
    cmp(16'(bank_selector_r), 16'h001F);
    rd(2'b00, 7'h70, 1, 8'hA5);
    rd(2'b00, 7'h20, 1, 8'h00);
    rd(2'b00, 7'h03, 1, 8'h1E);
    rd(2'b00, 7'h0C, 1, 8'h77);
    wr(7'h04, 8'h00, 4'h0);
    wr(7'h05, 8'h20, 4'h0);
    rd(2'b10, 7'h00, 1, 8'h3C);
    wr(7'h04, 8'h20, 4'h0);
    wr(7'h05, 8'h10, 4'h0);
    rd(2'b10, 7'h00, 1, 8'h00);
    wr(7'h06, 8'h23, 4'h0);
    wr(7'h07, 8'h81, 4'h0);
    cmp(ptr1_r, 16'h8123);
    rd(2'b11, 7'h00, 2, 8'h23);
    results();
  end
endmodule : cmaddr_core_tb_top
